// ---- asfr_top.v ----
// Serial frame readout of a simultaneously sampling converter
//
// Function
// - Data output undriven while chip select high
// - All channels captured on one common tick
// - Word size is 24 bits after reset
// - 32-bit words sign-extend the conversion result
// - Frame is status, channel words, CRC word
// - Short command frames accepted with channels off
// - Two-deep buffer; overflow halves ready rate
// - Only a complete frame retires the data
// - Unaligned align strobe sets resync flag
`timescale 1ns/10ps
`default_nettype none
`include "asfr_consts.vh"
module asfr_top #(
    parameter NCH           = 4,
    parameter SAMPLE_PERIOD = 16'd1000
) (
    input  wire                 core_clk,
    input  wire                 srst,
    input  wire                 cs_n,
    input  wire                 sclk,
    input  wire                 din,
    output reg                  dout,
    output reg                  dout_oe,
    output reg                  conversion_ready_n,
    input  wire                 sync_reset_n,
    input  wire [NCH*24-1:0]    conv_data
);
    localparam DW = NCH * `ASFR_SAMPLE_W;

    // Pin synchronisers; stage one feeds only stage two
    reg [2:0] cs_sync_r;
    reg [2:0] sclk_sync_r;
    reg [1:0] din_sync_r;
    reg [2:0] aln_sync_r;
    always @(posedge core_clk) begin
        if (srst) begin
            // Idle levels, so no false edge follows reset
            cs_sync_r   <= 3'h7;
            sclk_sync_r <= 3'h0;
            din_sync_r  <= 2'h0;
            aln_sync_r  <= 3'h7;
        end else begin
            cs_sync_r   <= {cs_sync_r[1:0], cs_n};
            sclk_sync_r <= {sclk_sync_r[1:0], sclk};
            din_sync_r  <= {din_sync_r[0], din};
            aln_sync_r  <= {aln_sync_r[1:0], sync_reset_n};
        end
    end
    wire cs_fall   = ~cs_sync_r[1] & cs_sync_r[2];
    wire cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
    wire sel       = ~cs_sync_r[1];
    wire sclk_rise = sel & sclk_sync_r[1] & ~sclk_sync_r[2];
    wire sclk_fall = sel & ~sclk_sync_r[1] & sclk_sync_r[2];
    wire aln_fall  = ~aln_sync_r[1] & aln_sync_r[2];

    // Config and state registers
    reg [15:0]              cfg_r;
    reg [15:0]              cmd_r;
    reg [15:0]              arg_r;
    reg                     wr_pend_r;
    reg [`ASFR_WIDX_W-1:0]  widx_r;
    reg [4:0]               bidx_r;
    reg [`ASFR_HOLD_W-1:0]  rx_r;
    reg [15:0]              crc_r;
    reg [15:0]              per_r;
    reg                     resync_flag_r;
    reg                     ovf_r;
    reg                     ovf_phase_r;

    wire                    wlen32  = cfg_r[`ASFR_CFG_WLEN32];
    wire                    crc_en  = cfg_r[`ASFR_CFG_CRC];
    wire [NCH-1:0]          ch_en   = cfg_r[`ASFR_CFG_CH_LO +: NCH];
    wire [4:0]              wtop    = wlen32 ? `ASFR_WLEN32 : `ASFR_WLEN24;
    wire                    all_off = (ch_en == {NCH{1'b0}});

    // Frame length; short frames allowed only with every channel off
    wire [31:0]             full_len_w = NCH + 1 + crc_en;
    wire [`ASFR_WIDX_W-1:0] full_len   = full_len_w[`ASFR_WIDX_W-1:0];
    wire [`ASFR_WIDX_W-1:0] frm_len  =
        all_off ? `ASFR_SHORT_LEN : full_len;
    wire                    frm_done = (widx_r >= frm_len);

    // Sample tick shared by every channel
    wire tick = (per_r == SAMPLE_PERIOD - 16'd1);

    // Result buffer
    wire          buf_in_ready;
    wire          buf_out_valid;
    wire [DW-1:0] buf_out_data;
    wire          buf_full;
    wire          pop = cs_rise & frm_done & ~all_off;
    asfr_buf2 #(
        .WIDTH (DW),
        .DEPTH (2)
    ) u_buf (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (tick),
        .in_ready  (buf_in_ready),
        .in_data   (conv_data),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data),
        .full      (buf_full)
    );

    // Status word, upper sixteen bits meaningful
    wire [15:0] status;
    assign status = {resync_flag_r, ovf_r, wlen32, crc_en,
                     {(12-NCH){1'b0}}, ch_en & {NCH{buf_out_valid}}};

    // Word presently being sent, MSB aligned in the 32-bit holder
    reg [`ASFR_HOLD_W-1:0]   word;
    reg [`ASFR_SAMPLE_W-1:0] samp;
    always @* begin
        word = {`ASFR_HOLD_W{1'b0}};
        samp = {`ASFR_SAMPLE_W{1'b0}};
        if (widx_r == `ASFR_WIDX_CMD) begin
            word = {status, `ASFR_PAD16};
        end else if (widx_r <= NCH) begin
            // Ascending channel order, disabled channels read zero
            samp = buf_out_data[(widx_r-1)*`ASFR_SAMPLE_W +:
                                `ASFR_SAMPLE_W];
            if (!ch_en[widx_r-1]) begin
                samp = {`ASFR_SAMPLE_W{1'b0}};
            end
            if (wlen32) begin
                word = {{8{samp[`ASFR_SAMPLE_W-1]}}, samp};
            end else begin
                word = {samp, `ASFR_PAD8};
            end
        end else if (widx_r == NCH + 1 && crc_en) begin
            word = {crc_r, `ASFR_PAD16};
        end
    end
    wire out_bit = word[`ASFR_HOLD_W - 1 - (wtop - bidx_r)];

    // Serial engine: drive on rising, sample on falling
    always @(posedge core_clk) begin
        if (srst) begin
            widx_r    <= `ASFR_WIDX_CMD;
            bidx_r    <= `ASFR_WLEN24;
            rx_r      <= {`ASFR_HOLD_W{1'b0}};
            cmd_r     <= `ASFR_PAD16;
            arg_r     <= `ASFR_PAD16;
            wr_pend_r <= 1'b0;
            crc_r     <= `ASFR_CRC_INIT;
            dout      <= 1'b0;
            dout_oe   <= 1'b0;
            cfg_r     <= `ASFR_CFG_RESET;
        end else begin
            // Lags the pin by the sync depth; a limit of sampling
            dout_oe <= sel;
            if (cs_fall) begin
                widx_r    <= `ASFR_WIDX_CMD;
                bidx_r    <= wtop;
                crc_r     <= `ASFR_CRC_INIT;
                wr_pend_r <= 1'b0;
            end
            if (sclk_rise) begin
                dout <= out_bit;
                if (widx_r <= NCH) begin
                    crc_r <= {crc_r[14:0], 1'b0} ^
                        ({16{crc_r[15] ^ out_bit}} & `ASFR_CRC_POLY);
                end
            end
            if (sclk_fall) begin
                rx_r <= {rx_r[`ASFR_HOLD_W-2:0], din_sync_r[1]};
                if (bidx_r == 5'h00) begin
                    bidx_r <= wtop;
                    if (widx_r != `ASFR_WIDX_MAX) begin
                        widx_r <= widx_r + 3'h1;
                    end
                    // Top sixteen bits were the first ones shifted in
                    if (widx_r == `ASFR_WIDX_CMD) begin
                        cmd_r <= rx_r[wtop-1 -: `ASFR_HALF_W];
                    end
                    if (widx_r == `ASFR_WIDX_ARG) begin
                        arg_r     <= rx_r[wtop-1 -: `ASFR_HALF_W];
                        wr_pend_r <= (cmd_r[15:12] == `ASFR_OPC_WRITE);
                    end
                end else begin
                    bidx_r <= bidx_r - 5'h01;
                end
            end
            // A write takes effect only at the end of a whole frame
            if (cs_rise) begin
                dout <= 1'b0;
                if (wr_pend_r & frm_done) begin
                    cfg_r <= arg_r;
                end
            end
        end
    end

    // Sample period, alignment strobe and resync flag
    always @(posedge core_clk) begin
        if (srst) begin
            per_r         <= `ASFR_CNT_ZERO;
            resync_flag_r <= 1'b0;
        end else begin
            if (aln_fall) begin
                per_r <= `ASFR_CNT_ZERO;
            end else if (tick) begin
                per_r <= `ASFR_CNT_ZERO;
            end else begin
                per_r <= per_r + 16'd1;
            end
            // Set wins over the clear by a completed read
            if (aln_fall && per_r != `ASFR_CNT_ZERO) begin
                resync_flag_r <= 1'b1;
            end else if (cs_rise & frm_done) begin
                resync_flag_r <= 1'b0;
            end
        end
    end

    // Ready output; overflow lets it fall only every second tick
    always @(posedge core_clk) begin
        if (srst) begin
            conversion_ready_n <= 1'b1;
            ovf_r              <= 1'b0;
            ovf_phase_r        <= 1'b0;
        end else begin
            // Set wins over a read's clear; a lone read still clears
            if (tick & buf_full) begin
                ovf_r <= 1'b1;
            end else if (pop) begin
                ovf_r <= 1'b0;
            end
            if (tick) begin
                ovf_phase_r <= buf_full & ~ovf_phase_r;
            end
            if (tick & ~all_off & (buf_in_ready | ovf_phase_r)) begin
                conversion_ready_n <= 1'b0;
            end else if (cs_fall) begin
                conversion_ready_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- asfr_consts.vh ----
// Constants for the serial frame readout block
`ifndef ASFR_CONSTS_VH
`define ASFR_CONSTS_VH

// Word geometry
`define ASFR_HOLD_W       32
`define ASFR_SAMPLE_W     24
`define ASFR_HALF_W       16
`define ASFR_WLEN24       5'h17
`define ASFR_WLEN32       5'h1f
`define ASFR_PAD8         8'h00
`define ASFR_PAD16        16'h0000

// Frame word indices
`define ASFR_WIDX_W       3
`define ASFR_WIDX_CMD     3'h0
`define ASFR_WIDX_ARG     3'h1
`define ASFR_WIDX_MAX     3'h7
`define ASFR_SHORT_LEN    3'h2

// Command word: write of the config word when top nibble matches
`define ASFR_OPC_WRITE    4'h6

// Config word fields and reset value (24 bit, no CRC, all on)
`define ASFR_CFG_WLEN32   0
`define ASFR_CFG_CRC      1
`define ASFR_CFG_CH_LO    2
`define ASFR_CFG_RESET    16'h003c

// Status word fields
`define ASFR_ST_RESYNC    15
`define ASFR_ST_OVF       14
`define ASFR_ST_WLEN      13

// Output CRC
`define ASFR_CRC_POLY     16'h1021
`define ASFR_CRC_INIT     16'hffff

// Sample period counter reset value
`define ASFR_CNT_ZERO     16'h0000

`endif

// ---- asfr_buf2.v ----
// Two-entry valid/ready buffer holding whole conversion results
`timescale 1ns/10ps
`default_nettype none
module asfr_buf2 #(
    parameter WIDTH = 96,
    parameter DEPTH = 2
) (
    input  wire             core_clk,
    input  wire             srst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [1:0]       cnt_r;
    reg [0:0]       rd_r;
    reg [0:0]       wr_r;
    wire            push;
    wire            pop;
    integer         i;

    // Honest flags straight from the fill count
    assign full      = (cnt_r == DEPTH);
    assign in_ready  = ~full;
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage and pointers
    always @(posedge core_clk) begin
        if (srst) begin
            cnt_r <= 2'h0;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem[wr_r] <= in_data;
                wr_r      <= ~wr_r;
            end
            if (pop) begin
                rd_r <= ~rd_r;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- asfr_top_properties.sv ----
// Port timing checks for the serial frame readout block
`timescale 1ns/10ps
`default_nettype none
module asfr_chk #(
    parameter SAMPLE_PERIOD = 1000
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conversion_ready_n
);
    logic        rdy_q_r;
    logic [15:0] gap_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Cycles since ready last fell; saturates so long stalls stay legal
    always @(posedge core_clk) begin
        rdy_q_r <= conversion_ready_n;
        if (srst || (rdy_q_r && !conversion_ready_n))
            gap_r <= 16'h0000;
        else if (gap_r != 16'hffff)
            gap_r <= gap_r + 16'h0001;
    end
    a_oe_drop: assert property (
        $rose(cs_n) |-> ##[1:4] !dout_oe)
        else $error("dout enable late after deselect");
    a_oe_off_idle: assert property (
        cs_n [*5] |-> !dout_oe)
        else $error("dout driven while deselected");
    a_dout_idle_zero: assert property (
        !dout_oe |-> !dout)
        else $error("dout not zero while undriven");
    a_bit_steady: assert property (
        (dout_oe && !sclk) [*2] |=> $stable(dout) || !dout_oe)
        else $error("dout moved without a clock rise");
    a_rdy_clear: assert property (
        $fell(cs_n) |-> ##[1:4] conversion_ready_n)
        else $error("ready not cleared by select");
    a_rdy_hold: assert property (
        !conversion_ready_n && cs_n |=> !conversion_ready_n)
        else $error("ready rose without a read");
    a_rdy_period: assert property (
        $fell(conversion_ready_n) |-> gap_r >= SAMPLE_PERIOD - 8)
        else $error("ready fell before a full period");
    a_reset_idle: assert property (
        $fell(srst) |-> !dout_oe && conversion_ready_n)
        else $error("outputs active after reset");
endmodule
bind asfr_top asfr_chk #(
    .SAMPLE_PERIOD(SAMPLE_PERIOD)
) i_asfr_chk (
    .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .dout(dout), .dout_oe(dout_oe),
    .conversion_ready_n(conversion_ready_n)
);
`default_nettype wire

// ---- asfr_host.sv ----
// Host serial port model that clocks frames through the converter
`timescale 1ns/10ps
`default_nettype none
module asfr_host (
    input  wire logic core_clk,
    input  wire logic dout,
    input  wire logic dout_oe,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic din,
    output var  logic sync_reset_n
);
    logic [31:0] rx [0:7];
    // Idle levels; align input held high when unused
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        sync_reset_n = 1'b1;
    end
    // Sole device selected, low for the whole frame
    task automatic frame(input int nw, input int wl,
                         input logic [31:0] w0, input logic [31:0] w1);
        int          w;
        int          b;
        logic [31:0] tx;
        cs_n = 1'b0;
        repeat (4) @(negedge core_clk);
        for (w = 0; w < nw; w++) begin
            tx = (w == 0) ? w0 : (w == 1) ? w1 : 32'h0000_0000;
            rx[w] = 32'h0000_0000;
            for (b = wl - 1; b >= 0; b--) begin
                sclk = 1'b1;
                din = tx[b];
                repeat (4) @(negedge core_clk);
                sclk = 1'b0;
                repeat (4) @(negedge core_clk);
                // Undriven line has no pull, so model it as toggling
                rx[w][b] = dout_oe ? dout : b[0];
            end
        end
        cs_n = 1'b1;
        din = ~din;
        repeat (6) @(negedge core_clk);
    endtask
    // Align strobe, shared by all devices in a group
    task automatic align;
        sync_reset_n = 1'b0;
        repeat (4) @(negedge core_clk);
        sync_reset_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- asfr_top_tb_top.sv ----
// Self-checking bench for the serial frame readout block
`timescale 1ns/10ps
`default_nettype none
module asfr_top_tb_top;
    localparam int SP = 4000;
    logic        core_clk;
    logic        srst;
    logic [23:0] ch0;
    int          mismatches;
    int          n_checks;
    wire         cs_n;
    wire         sclk;
    wire         din;
    wire         sync_reset_n;
    wire         dout;
    wire         dout_oe;
    wire         conversion_ready_n;
    wire  [95:0] conv_data = {24'h7f_ffff, 24'h00_0001, 24'h12_3456, ch0};
    asfr_top #(
        .NCH(4),
        .SAMPLE_PERIOD(16'h0fa0)
    ) i_asfr_top (
        .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .dout_oe(dout_oe),
        .conversion_ready_n(conversion_ready_n),
        .sync_reset_n(sync_reset_n), .conv_data(conv_data)
    );
    asfr_host i_asfr_host (
        .core_clk(core_clk), .dout(dout), .dout_oe(dout_oe),
        .cs_n(cs_n), .sclk(sclk), .din(din), .sync_reset_n(sync_reset_n)
    );
    // 100 ns core clock
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    function automatic logic [31:0] rx(input int i);
        return i_asfr_host.rx[i];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait; reading only after ready falls
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 2 * SP && conversion_ready_n !== 1'b0; i++)
            @(negedge core_clk);
        chk({31'h0, conversion_ready_n}, 32'h0);
    endtask
    // Output CRC as the host recomputes it, MSB first over words 0..nw-1
    function automatic logic [15:0] crc_of(input int nw);
        logic [15:0] c;
        int          w;
        int          b;
        c = 16'hffff;
        for (w = 0; w < nw; w++)
            for (b = 31; b >= 0; b--)
                c = {c[14:0], 1'b0} ^
                    ({16{c[15] ^ i_asfr_host.rx[w][b]}} & 16'h1021);
        return c;
    endfunction
    // Default 24-bit frame: status, channels ascending, empty CRC slot
    task automatic t_default;
        wait_rdy();
        i_asfr_host.frame(6, 24, 0, 0);
        chk(rx(0) & 32'h0020_0000, 32'h0);
        chk(rx(0) & 32'h0000_0f00, 32'h0000_0f00);
        chk(rx(1), 32'h0080_0001);
        chk(rx(2), 32'h0012_3456);
        chk(rx(3), 32'h0000_0001);
        chk(rx(4), 32'h007f_ffff);
        chk(rx(5), 32'h0000_0000);
    endtask
    // Partial frame keeps the entry; both entries then drain in order
    task automatic t_repeat;
        ch0 = 24'h00_0aaa;
        wait_rdy();
        ch0 = 24'h00_0bbb;
        i_asfr_host.frame(2, 24, 0, 0);
        wait_rdy();
        i_asfr_host.frame(6, 24, 0, 0);
        chk(rx(1), 32'h0000_0aaa);
        i_asfr_host.frame(6, 24, 0, 0);
        chk(rx(1), 32'h0000_0bbb);
    endtask
    // Channels off, then a two-word write turns on 32-bit words
    task automatic t_short;
        wait_rdy();
        i_asfr_host.frame(6, 24, 24'h60_0000, 24'h00_0000);
        i_asfr_host.frame(2, 24, 24'h60_0000, 24'h00_3d00);
        ch0 = 24'h80_0001;
        wait_rdy();
        i_asfr_host.frame(6, 32, 0, 0);
        chk(rx(0) & 32'h2000_0000, 32'h2000_0000);
        chk(rx(1), 32'hff80_0001);
        chk(rx(2), 32'h0012_3456);
    endtask
    // Three unread ticks: newest dropped, flag set, oldest read first
    // Waits by counting clock periods once synced to ready
    task automatic t_ovf;
        ch0 = 24'h00_0d01;
        wait_rdy();
        ch0 = 24'h00_0d02;
        repeat (SP + SP / 2) @(negedge core_clk);
        ch0 = 24'h00_0d03;
        repeat (SP / 2 + 100) @(negedge core_clk);
        i_asfr_host.frame(6, 32, 0, 0);
        chk(rx(0) & 32'h4000_0000, 32'h4000_0000);
        chk(rx(1), 32'h0000_0d01);
        i_asfr_host.frame(6, 32, 0, 0);
        chk(rx(1), 32'h0000_0d02);
    endtask
    // Align strobe in mid-period raises the resync flag
    task automatic t_resync;
        repeat (SP / 2) @(negedge core_clk);
        i_asfr_host.align();
        wait_rdy();
        i_asfr_host.frame(6, 32, 0, 0);
        chk(rx(0) & 32'h8000_0000, 32'h8000_0000);
    endtask
    // Sole device on the bus, so the output CRC guards each frame
    task automatic t_crc;
        i_asfr_host.frame(6, 32, 32'h6000_0000, 32'h003f_0000);
        wait_rdy();
        i_asfr_host.frame(6, 32, 0, 0);
        chk(rx(0) & 32'h100f_0000, 32'h100f_0000);
        chk(rx(1), 32'h0000_0d03);
        chk(rx(5), {crc_of(5), 16'h0000});
    endtask
    // Main sequence, reset held four cycles
    initial begin
        srst = 1'b1;
        ch0 = 24'h80_0001;
        mismatches = 0;
        n_checks = 0;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        t_default();
        t_repeat();
        t_short();
        t_ovf();
        t_resync();
        t_crc();
        tally_and_finish();
    end
    // Watchdog: about twice the expected run
    initial begin
        repeat (80000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
